// file: rtl/scc_pkg.sv
// Shared constants and types of the stepper chopper control block
package scc_pkg;
    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 10;
    localparam int CLK_FREQ_KHZ    = 100000;
    localparam int OSC_FREQ_KHZ    = 1600;
    localparam int OSC_DIV_DEF     = CLK_FREQ_KHZ / OSC_FREQ_KHZ;
    localparam int CHOP_OSC_CYCLES = 16;
    localparam int CHOP_PHASE_W    = 4;
    localparam logic [3:0] CHOP_LAST = 4'(CHOP_OSC_CYCLES - 1);
    localparam int ISD_MASK_OSC    = 4;
    localparam int ISD_ON_MAX_OSC  = 8;
    localparam int ISD_CNT_W       = 3;
    localparam logic [2:0] ISD_TRIP_CNT = 3'(ISD_MASK_OSC - 1);
    localparam int BLANK_NS        = 400;
    localparam int BLANK_W         = 6;
    localparam logic [5:0] BLANK_CYC =
        6'((BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // ------------------------------------------------------------------
    // Pin synchroniser layout
    // ------------------------------------------------------------------
    localparam int NUM_WINDINGS = 2;
    localparam int SYN_W        = 10;
    localparam int SYN_CTRL0    = 0;
    localparam int SYN_REACH0   = 4;
    localparam int SYN_SHORT0   = 6;
    localparam int SYN_TEMP     = 8;
    localparam int SYN_STBY     = 9;
    // ------------------------------------------------------------------
    // Control codes {ctrl_1, ctrl_2}, levels, switch patterns
    // ------------------------------------------------------------------
    localparam logic [1:0] CTRL_OFF      = 2'h0;
    localparam logic [1:0] CTRL_FWD      = 2'h1;
    localparam logic [1:0] CTRL_REV      = 2'h2;
    localparam logic [1:0] CTRL_REDUCED  = 2'h3;
    localparam logic [1:0] LEVEL_ZERO    = 2'h0;
    localparam logic [1:0] LEVEL_REDUCED = 2'h2;
    localparam logic [1:0] LEVEL_FULL    = 2'h3;
    localparam int SW_HS1 = 3;
    localparam int SW_HS2 = 2;
    localparam int SW_LS1 = 1;
    localparam int SW_LS2 = 0;
    localparam logic [3:0] SW_OFF      = 4'h0;
    localparam logic [3:0] SW_CHG_FWD  = 4'h9;
    localparam logic [3:0] SW_FAST_FWD = 4'h6;
    localparam logic [3:0] SW_CHG_REV  = 4'h6;
    localparam logic [3:0] SW_FAST_REV = 4'h9;
    localparam logic [3:0] SW_SLOW     = 4'h3;
    typedef enum logic [1:0] {SCC_OFF, SCC_CHARGE, SCC_SLOW, SCC_FAST}
        scc_mode_e;
endpackage

// file: rtl/scc_winding_bridge.sv
// One winding: chop state sequencer and H-bridge switch drive
`timescale 1ns/100ps
`default_nettype none
module scc_winding_bridge
    import scc_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       reset_n_in,
    // Sequencing from the top
    input  wire logic       enable_in,
    input  wire logic       chop_start_in,
    input  wire logic       ctrl_1_in,
    input  wire logic       ctrl_2_in,
    input  wire logic       current_reached_in,
    // Bridge drive
    output logic [3:0]      switches_out,
    output logic [1:0]      level_out
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        scc_mode_e            mode;
        logic                 rev;
        logic [1:0]           last;
        logic                 fast_pending;
        logic                 use_fast;
        logic [BLANK_W-1:0]   blank;
        logic [3:0]           sw;
        logic [1:0]           level;
    } scc_wb_s;

    scc_wb_s    s;
    scc_wb_s    next_s;
    logic [1:0] tgt;
    logic       changed;

    function automatic logic [3:0] bridge_sw(scc_mode_e m, logic r);
        logic [3:0] v;
        v = SW_OFF;
        unique case (m)
            SCC_OFF:    v = SW_OFF;
            SCC_CHARGE: v = r ? SW_CHG_REV : SW_CHG_FWD;
            SCC_SLOW:   v = SW_SLOW;
            SCC_FAST:   v = r ? SW_FAST_REV : SW_FAST_FWD;
        endcase
        return v;
    endfunction

    assign tgt     = {ctrl_1_in, ctrl_2_in};
    assign changed = (tgt != s.last);

    always_comb
    begin
        next_s = s;
        if (!enable_in || tgt == CTRL_OFF)
        begin
            next_s.mode         = SCC_OFF;
            next_s.blank        = '0;
            next_s.fast_pending = 1'b1;
            next_s.last         = tgt;
        end
        else
        begin
            next_s.rev  = (tgt == CTRL_REV);
            next_s.last = tgt;
            if (chop_start_in || s.mode == SCC_OFF)
            begin
                next_s.mode         = SCC_CHARGE;
                next_s.blank        = BLANK_CYC;
                next_s.use_fast     = s.fast_pending || changed;
                next_s.fast_pending = 1'b0;
            end
            else if (changed)
            begin
                next_s.fast_pending = 1'b1;
                next_s.blank        = BLANK_CYC;
            end
            else if (s.blank != '0)
                next_s.blank = s.blank - 1'b1;
            else if (s.mode == SCC_CHARGE && current_reached_in)
            begin
                // Fast decay only right after a target change or a spell in off, to track it
                next_s.mode  = s.use_fast ? SCC_FAST : SCC_SLOW;
                next_s.blank = BLANK_CYC;
            end
        end
        next_s.sw = bridge_sw(next_s.mode, next_s.rev);
        unique case (tgt)
            CTRL_OFF:     next_s.level = LEVEL_ZERO;
            CTRL_FWD:     next_s.level = LEVEL_FULL;
            CTRL_REV:     next_s.level = LEVEL_FULL;
            CTRL_REDUCED: next_s.level = LEVEL_REDUCED;
        endcase
        if (next_s.mode == SCC_OFF)
            next_s.level = LEVEL_ZERO;
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            s <= '0;
        else
            s <= next_s;
    end

    assign switches_out = s.sw;
    assign level_out    = s.level;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_fwd_table;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        !s.rev |-> s.sw == (s.mode == SCC_CHARGE ? SW_CHG_FWD :
                  s.mode == SCC_FAST ? SW_FAST_FWD :
                  s.mode == SCC_SLOW ? SW_SLOW : SW_OFF);
    endproperty
    a_fwd_table: assert property (p_fwd_table)
        else $error("forward switch pattern wrong");

    property p_rev_table;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        s.rev |-> s.sw == (s.mode == SCC_CHARGE ? SW_CHG_REV :
                 s.mode == SCC_FAST ? SW_FAST_REV :
                 s.mode == SCC_SLOW ? SW_SLOW : SW_OFF);
    endproperty
    a_rev_table: assert property (p_rev_table)
        else $error("reverse switch pattern wrong");

    property p_no_shoot;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        !(s.sw[SW_HS1] && s.sw[SW_LS1]) && !(s.sw[SW_HS2] && s.sw[SW_LS2]);
    endproperty
    a_no_shoot: assert property (p_no_shoot)
        else $error("bridge leg shorted");

    property p_blank_hold;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (s.mode == SCC_CHARGE && s.blank != '0 && enable_in &&
         !chop_start_in && !changed && tgt != CTRL_OFF)
        |=> s.mode == SCC_CHARGE;
    endproperty
    a_blank_hold: assert property (p_blank_hold)
        else $error("comparator acted during blanking");

    property p_cycle_charge;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (chop_start_in && enable_in && tgt != CTRL_OFF)
        |=> s.mode == SCC_CHARGE && s.blank == BLANK_CYC;
    endproperty
    a_cycle_charge: assert property (p_cycle_charge)
        else $error("chop cycle did not start in charge");

    property p_decay_hold;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        ((s.mode == SCC_SLOW || s.mode == SCC_FAST) && enable_in &&
         !chop_start_in && tgt != CTRL_OFF)
        |=> s.mode == $past(s.mode);
    endproperty
    a_decay_hold: assert property (p_decay_hold)
        else $error("decay left before cycle boundary");

    property p_off_pins;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (!enable_in || tgt == CTRL_OFF)
        |=> s.sw == SW_OFF && s.level == LEVEL_ZERO;
    endproperty
    a_off_pins: assert property (p_off_pins)
        else $error("switches on while disabled");

    c_slow: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        s.mode == SCC_CHARGE ##1 s.mode == SCC_SLOW);
    c_fast: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        s.mode == SCC_CHARGE ##1 s.mode == SCC_FAST);
endmodule
`default_nettype wire

// file: rtl/scc_stepper_chopper_control.sv
// Top of the two-winding stepper chopper control with shutdown latches
// Function
// - Chop cycle spans sixteen oscillator periods
// - Ignore overcurrent for four oscillator cycles
// - Enter overcurrent shutdown within eight cycles
// - Forward direction switch table per mode
// - Reverse direction switch table per mode
// - Regulate using only charge, slow, fast
// - Blank comparator after each switching event
// - Overcurrent shutdown holds switches off until standby
// - Thermal shutdown latches switches off until standby
`timescale 1ns/100ps
`default_nettype none
module scc_stepper_chopper_control
    import scc_pkg::*;
#(
    parameter int OSC_DIV = OSC_DIV_DEF
)
(
    // Clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       reset_n_in,
    // Host and sensing pins, asynchronous
    input  wire logic       standby_n_in,
    input  wire logic       winding_a_ctrl_1_in,
    input  wire logic       winding_a_ctrl_2_in,
    input  wire logic       winding_b_ctrl_1_in,
    input  wire logic       winding_b_ctrl_2_in,
    input  wire logic       current_reached_a_in,
    input  wire logic       current_reached_b_in,
    input  wire logic       short_detect_a_in,
    input  wire logic       short_detect_b_in,
    input  wire logic       over_temp_in,
    // Winding A bridge
    output logic            winding_a_high_side_switch_1_out,
    output logic            winding_a_high_side_switch_2_out,
    output logic            winding_a_low_side_switch_1_out,
    output logic            winding_a_low_side_switch_2_out,
    output logic [1:0]      winding_a_level_out,
    // Winding B bridge
    output logic            winding_b_high_side_switch_1_out,
    output logic            winding_b_high_side_switch_2_out,
    output logic            winding_b_low_side_switch_1_out,
    output logic            winding_b_low_side_switch_2_out,
    output logic [1:0]      winding_b_level_out,
    // Status
    output logic            overcurrent_shutdown_out,
    output logic            thermal_shutdown_out,
    output logic            chop_ref_oscillator_out
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    localparam int DIV_W = (OSC_DIV > 1) ? $clog2(OSC_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV - 1);

    typedef struct packed {
        logic [SYN_W-1:0]        sync1;
        logic [SYN_W-1:0]        sync2;
        logic [DIV_W-1:0]        div;
        logic [CHOP_PHASE_W-1:0] phase;
        logic                    osc_tick;
        logic                    chop_start;
        logic [ISD_CNT_W-1:0]    isd_cnt;
        logic                    oc;
        logic                    th;
    } scc_top_s;

    scc_top_s         s;
    scc_top_s         next_s;
    logic [SYN_W-1:0] raw;
    logic             stby;
    logic             short_any;
    logic             run;
    logic [3:0]       sw  [NUM_WINDINGS];
    logic [1:0]       lvl [NUM_WINDINGS];

    assign raw = {standby_n_in, over_temp_in,
                  short_detect_b_in, short_detect_a_in,
                  current_reached_b_in, current_reached_a_in,
                  winding_b_ctrl_2_in, winding_b_ctrl_1_in,
                  winding_a_ctrl_2_in, winding_a_ctrl_1_in};

    // Only the second synchroniser stage is ever read below
    assign stby      = s.sync2[SYN_STBY];
    assign short_any = |s.sync2[SYN_SHORT0 +: NUM_WINDINGS];
    assign run       = stby && !s.oc && !s.th;

    // ------------------------------------------------------------------
    // Oscillator, chop timing and protection
    // ------------------------------------------------------------------
    always_comb
    begin
        next_s            = s;
        next_s.sync1      = raw;
        next_s.sync2      = s.sync1;
        next_s.osc_tick   = 1'b0;
        next_s.chop_start = 1'b0;
        if (!stby)
        begin
            // Standby initialises divider, phase and short count and clears both latches
            next_s.div     = '0;
            next_s.phase   = '0;
            next_s.isd_cnt = '0;
            next_s.oc      = 1'b0;
            next_s.th      = 1'b0;
        end
        else
        begin
            if (s.sync2[SYN_TEMP])
                next_s.th = 1'b1;
            // Oscillator stands still while overcurrent shutdown holds
            if (!s.oc)
            begin
                if (s.div == DIV_LAST)
                begin
                    next_s.div      = '0;
                    next_s.osc_tick = 1'b1;
                    next_s.phase    = s.phase + 1'b1;
                    if (s.phase == CHOP_LAST)
                        next_s.chop_start = 1'b1;
                end
                else
                    next_s.div = s.div + 1'b1;
            end
            if (!short_any)
                next_s.isd_cnt = '0;
            else if (s.osc_tick && !s.oc)
            begin
                if (s.isd_cnt == ISD_TRIP_CNT)
                    next_s.oc = 1'b1;
                else
                    next_s.isd_cnt = s.isd_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            s <= '0;
        else
            s <= next_s;
    end

    // ------------------------------------------------------------------
    // Windings
    // ------------------------------------------------------------------
    for (genvar w = 0; w < NUM_WINDINGS; w++)
    begin : g_wind
        scc_winding_bridge u_bridge
        (
            .ref_clk_in         (ref_clk_in),
            .reset_n_in         (reset_n_in),
            .enable_in          (run),
            .chop_start_in      (s.chop_start),
            .ctrl_1_in          (s.sync2[SYN_CTRL0 + 2*w]),
            .ctrl_2_in          (s.sync2[SYN_CTRL0 + 2*w + 1]),
            .current_reached_in (s.sync2[SYN_REACH0 + w]),
            .switches_out       (sw[w]),
            .level_out          (lvl[w])
        );
    end

    assign winding_a_high_side_switch_1_out = sw[0][SW_HS1];
    assign winding_a_high_side_switch_2_out = sw[0][SW_HS2];
    assign winding_a_low_side_switch_1_out  = sw[0][SW_LS1];
    assign winding_a_low_side_switch_2_out  = sw[0][SW_LS2];
    assign winding_a_level_out              = lvl[0];
    assign winding_b_high_side_switch_1_out = sw[1][SW_HS1];
    assign winding_b_high_side_switch_2_out = sw[1][SW_HS2];
    assign winding_b_low_side_switch_1_out  = sw[1][SW_LS1];
    assign winding_b_low_side_switch_2_out  = sw[1][SW_LS2];
    assign winding_b_level_out              = lvl[1];
    assign overcurrent_shutdown_out         = s.oc;
    assign thermal_shutdown_out             = s.th;
    assign chop_ref_oscillator_out          = s.osc_tick;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    localparam int ISD_BOUND_CYC = ISD_ON_MAX_OSC * OSC_DIV;
    localparam int HC_W = $clog2(ISD_BOUND_CYC + 2);

    logic [4:0]      tick_cnt;
    logic            seen_start;
    logic [2:0]      held_ticks;
    logic [HC_W-1:0] held_cyc;
    logic            all_off;

    assign all_off = (sw[0] == SW_OFF) && (sw[1] == SW_OFF);

    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            tick_cnt   <= '0;
            seen_start <= 1'b0;
            held_ticks <= '0;
            held_cyc   <= '0;
        end
        else
        begin
            if (!stby || s.chop_start)
                tick_cnt <= '0;
            else if (s.osc_tick)
                tick_cnt <= tick_cnt + 1'b1;
            seen_start <= stby && (seen_start || s.chop_start);
            if (!short_any || !stby || s.oc)
                held_ticks <= '0;
            else if (s.osc_tick && held_ticks != 3'h7)
                held_ticks <= held_ticks + 1'b1;
            if (!short_any || !stby || s.oc)
                held_cyc <= '0;
            else if (held_cyc != '1)
                held_cyc <= held_cyc + 1'b1;
        end
    end

    property p_chop_period;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (s.chop_start && seen_start) |-> tick_cnt == 5'(CHOP_OSC_CYCLES-1);
    endproperty
    a_chop_period: assert property (p_chop_period)
        else $error("chop cycle not sixteen oscillator periods");

    property p_isd_mask;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        $rose(s.oc) |-> held_ticks == 3'(ISD_MASK_OSC);
    endproperty
    a_isd_mask: assert property (p_isd_mask)
        else $error("overcurrent tripped off the mask count");

    property p_isd_bound;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        held_cyc <= HC_W'(ISD_BOUND_CYC);
    endproperty
    a_isd_bound: assert property (p_isd_bound)
        else $error("overcurrent shutdown entry too slow");

    property p_isd_hold;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (s.oc && stby) |=> s.oc && all_off;
    endproperty
    a_isd_hold: assert property (p_isd_hold)
        else $error("overcurrent shutdown released or switches on");

    property p_tsd_hold;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (s.th && stby) |=> s.th && all_off;
    endproperty
    a_tsd_hold: assert property (p_tsd_hold)
        else $error("thermal shutdown released or switches on");

    c_isd_trip: cover property (@(posedge ref_clk_in)
        disable iff (!reset_n_in) $rose(s.oc));
    c_tsd_trip: cover property (@(posedge ref_clk_in)
        disable iff (!reset_n_in) $rose(s.th));
endmodule
`default_nettype wire

// file: tb/scc_host_model.sv
// Host controller model that drives the winding control pin pairs
`timescale 1ns/100ps
`default_nettype none
module scc_host_model
    import scc_pkg::*;
(
    // Clock and supply state
    input  wire logic       ref_clk_in,
    input  wire logic       supply_ok_in,
    // Wanted codes per winding
    input  wire logic [1:0] cmd_a_in,
    input  wire logic [1:0] cmd_b_in,
    // Control pins
    output var logic [1:0]  ctrl_a_out = 2'h0,
    output var logic [1:0]  ctrl_b_out = 2'h0
);
    always @(posedge ref_clk_in)
    begin
        ctrl_a_out <= supply_ok_in ? cmd_a_in : CTRL_OFF;
        ctrl_b_out <= supply_ok_in ? cmd_b_in : CTRL_OFF;
    end
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench of the stepper chopper control block
`timescale 1ns/100ps
`default_nettype none
module tb;
    import scc_pkg::*;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    localparam int DIV = 4;
    logic clk = 1'b0, rst_n = 1'b0, stby_n = 1'b0, sup = 1'b0;
    logic [1:0] cmd_a = 2'h0, cmd_b = 2'h0, ca, cb;
    logic cur_a = 1'b0, cur_b = 1'b0, sh_a = 1'b0, sh_b = 1'b0;
    logic temp = 1'b0;
    logic [3:0] sw_a, sw_b;
    logic [1:0] lv_a, lv_b;
    logic oc, th, osc;
    logic [3:0] osc_n = 4'h0;
    int miscompares = 0, cmp_count = 0, n, n1;
    always #5 clk = ~clk;
    scc_host_model i_scc_host_model (.ref_clk_in(clk), .supply_ok_in(sup),
        .cmd_a_in(cmd_a), .cmd_b_in(cmd_b), .ctrl_a_out(ca),
        .ctrl_b_out(cb));
    scc_stepper_chopper_control #(.OSC_DIV(DIV)) i_scc_stepper_chopper_control
    (
        .ref_clk_in(clk), .reset_n_in(rst_n), .standby_n_in(stby_n),
        .winding_a_ctrl_1_in(ca[1]), .winding_a_ctrl_2_in(ca[0]),
        .winding_b_ctrl_1_in(cb[1]), .winding_b_ctrl_2_in(cb[0]),
        .current_reached_a_in(cur_a), .current_reached_b_in(cur_b),
        .short_detect_a_in(sh_a), .short_detect_b_in(sh_b),
        .over_temp_in(temp),
        .winding_a_high_side_switch_1_out(sw_a[3]),
        .winding_a_high_side_switch_2_out(sw_a[2]),
        .winding_a_low_side_switch_1_out(sw_a[1]),
        .winding_a_low_side_switch_2_out(sw_a[0]),
        .winding_a_level_out(lv_a),
        .winding_b_high_side_switch_1_out(sw_b[3]),
        .winding_b_high_side_switch_2_out(sw_b[2]),
        .winding_b_low_side_switch_1_out(sw_b[1]),
        .winding_b_low_side_switch_2_out(sw_b[0]),
        .winding_b_level_out(lv_b),
        .overcurrent_shutdown_out(oc), .thermal_shutdown_out(th),
        .chop_ref_oscillator_out(osc)
    );
    // Oscillator pulses since standby; the sixteenth closes a chop cycle
    always @(posedge clk)
    begin
        if (!stby_n)
            osc_n <= 4'h0;
        else if (osc)
            osc_n <= osc_n + 4'h1;
    end
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wait_sw(input logic [3:0] exp, input int max,
                           output int cnt);
        cnt = 0;
        while (sw_a !== exp && cnt < max)
        begin
            @(negedge clk);
            cnt++;
        end
        chk({4'h0, sw_a}, {4'h0, exp});
        if (cnt >= max)
            summarize();
    endtask
    // Align to a chop boundary so a whole charge and decay fits one cycle
    task automatic wait_boundary();
        int cnt;
        cnt = 0;
        while (!(osc === 1'b1 && osc_n == CHOP_LAST) && cnt < 200)
        begin
            @(negedge clk);
            cnt++;
        end
        if (cnt >= 200)
        begin
            miscompares++;
            summarize();
        end
    endtask
    task automatic idle(input int c);
        repeat (c) @(negedge clk);
    endtask
    // Pulse standby low to clear latches; host codes back to off
    task automatic init_pulse();
        @(posedge clk);
        stby_n <= 1'b0;
        cmd_a <= CTRL_OFF;
        cmd_b <= CTRL_OFF;
        idle(6);
        chk({oc, th}, 8'h0);
        @(posedge clk);
        stby_n <= 1'b1;
        idle(6);
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_supply();
        @(posedge clk);
        cmd_a <= CTRL_FWD;
        idle(20);
        chk({sw_a, sw_b}, 8'h0);
        $display("test supply done");
    endtask
    task automatic t_chop();
        wait_boundary();
        @(posedge clk);
        sup <= 1'b1;
        cur_a <= 1'b1;
        cmd_b <= CTRL_REV;
        wait_sw(SW_CHG_FWD, 20, n);
        chk({6'h0, lv_a}, {6'h0, LEVEL_FULL});
        chk({4'h0, sw_b}, {4'h0, SW_CHG_REV});
        chk({6'h0, lv_b}, {6'h0, LEVEL_FULL});
        wait_sw(SW_FAST_FWD, 100, n);
        if (n < int'(BLANK_CYC))
            chk(8'(n), 8'(BLANK_CYC));
        wait_sw(SW_CHG_FWD, 100, n);
        wait_sw(SW_SLOW, 100, n1);
        wait_sw(SW_CHG_FWD, 100, n);
        chk(8'(n + n1), 8'(CHOP_OSC_CYCLES * DIV));
        @(posedge clk);
        cmd_a <= CTRL_REDUCED;
        idle(8);
        chk({6'h0, lv_a}, {6'h0, LEVEL_REDUCED});
        $display("test chop done");
    endtask
    task automatic t_overcurrent();
        @(posedge clk);
        sh_a <= 1'b1;
        n = 0;
        while (oc !== 1'b1 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        if (n < 3 * DIV)
            chk(8'(n), 8'(3 * DIV));
        if (n > ISD_ON_MAX_OSC * DIV + 4)
            chk(8'(n), 8'(ISD_ON_MAX_OSC * DIV));
        if (n >= 200)
            summarize();
        idle(2);
        chk({sw_a, sw_b}, 8'h0);
        @(posedge clk);
        sh_a <= 1'b0;
        idle(100);
        chk({7'h0, oc}, 8'h01);
        chk({sw_a, sw_b}, 8'h00);
        init_pulse();
        $display("test overcurrent done");
    endtask
    task automatic t_thermal();
        @(posedge clk);
        cmd_a <= CTRL_FWD;
        cmd_b <= CTRL_FWD;
        idle(8);
        chk({4'h0, sw_a}, {4'h0, SW_CHG_FWD});
        @(posedge clk);
        temp <= 1'b1;
        idle(6);
        chk({7'h0, th}, 8'h01);
        chk({sw_a, sw_b}, 8'h00);
        @(posedge clk);
        temp <= 1'b0;
        idle(80);
        chk({7'h0, th}, 8'h01);
        chk({sw_a, sw_b}, 8'h00);
        init_pulse();
        $display("test thermal done");
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        stby_n <= 1'b1;
        idle(4);
        t_supply();
        t_chop();
        t_overcurrent();
        t_thermal();
        summarize();
    end
endmodule
`default_nettype wire
